// >>> common/ptp_pkg.sv
// constants for the power-to-pulse-rate output stage
package ptp_pkg;
  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 32'h017D7840;   // 25 MHz system clock
  localparam int unsigned OSC_HZ = 32'h0006DDD0;   // 450 kHz nominal oscillator
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [5:0] OSC_DIV_LAST = 6'(OSC_DIV - 1);

  // ----------------------------------------------------------------
  // power scaling
  // ----------------------------------------------------------------
  localparam int PWR_W = 16;
  localparam int ACC_W = 40;
  localparam int CNT_W = 26;
  localparam logic [PWR_W-1:0] PWR_FS = 16'h4000;  // full-scale ac product
  localparam longint unsigned MAX_RATE_PERMILLE = 64'hCC;  // 0.204 x base rate
  localparam longint unsigned PERMILLE = 64'h3E8;
  // power-ticks per slow pulse at base rate osc/2^16
  localparam longint unsigned K_FULL = (64'(PWR_FS) * 64'h10000 * PERMILLE)
                                       / MAX_RATE_PERMILLE;
  localparam logic [ACC_W-1:0] CAL_THR_HI = ACC_W'(K_FULL / 64'h10);
  localparam logic [ACC_W-1:0] CAL_THR_LO = ACC_W'(K_FULL / 64'h8);
  localparam logic [ACC_W-1:0] CAL_THR_HF = ACC_W'(K_FULL / 64'h800);
  // no-load floor: 0.0014 % of base, i.e. 14 per million
  localparam longint unsigned NOLOAD_PPM = 64'hE;
  localparam logic [PWR_W-1:0] PWR_MIN = PWR_W'((64'(PWR_FS) * NOLOAD_PPM
                                          + 64'h31CE0 - 64'h1) / 64'h31CE0);
  localparam logic [11:0] MULT_HF = 12'h800;
  localparam logic [11:0] MULT_HI_BASE = 12'h080;
  localparam logic [11:0] MULT_LO_BASE = 12'h040;

  // ----------------------------------------------------------------
  // pulse timing
  // ----------------------------------------------------------------
  localparam int unsigned SLOW_SHORT_MS = 32'h426;  // 1062 ms
  localparam int unsigned CAL_SHORT_MS = 32'h15A;   // 346 ms
  localparam int unsigned CAL_WIDTH_MS = 32'hAD;    // 173 ms
  localparam int unsigned HF_WIDTH_US = 32'h23;     // 35 us
  localparam int unsigned SLOW_SHORT_CYC = (CLK_HZ / 32'h3E8) * SLOW_SHORT_MS;
  localparam int unsigned CAL_SHORT_CYC = (CLK_HZ / 32'h3E8) * CAL_SHORT_MS;
  localparam logic [CNT_W-1:0] HF_WIDTH_CYC = CNT_W'((CLK_HZ / 32'hF4240) * HF_WIDTH_US);
endpackage

// >>> hw/ptp_out.sv
// pulse-rate output stage: power accumulators, slow and calibration pulse outputs
// Function
// - slow outputs carry real-power rate as active-low pulses
// - base rate is oscillator divided by 2^19..2^16 per rate selects
// - slow rate scales with product of rms voltages and base rate
// - slow rate comes from long accumulation of filtered power
// - full-scale slow rate is 0.204 of the base rate
// - calibration multiplier 128/64/32/16, or 64/32/16/2048 with scale low
// - calibration output accumulates same power over a shorter interval
// - high-frequency mode gives about 2.867 kHz at full scale
// - every rate scales with the 450 kHz oscillator
// - slow outputs alternate; below 1062 ms period width is half period
// - calibration pulses active high, 173 ms, half period below 346 ms
// - high-frequency mode calibration pulse is fixed 35 us
// - no pulses when rate below 0.0014 % of base rate
`timescale 1ns/100ps
module ptp_out
  import ptp_pkg::*;
#(
  parameter int unsigned SLOW_SHORT = SLOW_SHORT_CYC,
  parameter int unsigned CAL_SHORT = CAL_SHORT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // filtered real power, unsigned, full scale PWR_FS
  input wire logic [PWR_W-1:0] power_i,
  // mode selects
  input wire logic rate_sel_lo_i,
  input wire logic rate_sel_hi_i,
  input wire logic cal_scale_sel_i,
  // pulse outputs
  output logic slow_pulse_a_n_o,
  output logic slow_pulse_b_n_o,
  output logic cal_pulse_out_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // width is half the shorter of last period and the short limit
  function automatic logic [CNT_W-1:0] half_min(input logic [CNT_W-1:0] per,
                                               input logic [CNT_W-1:0] lim);
    logic [CNT_W-1:0] m;
    m = (per < lim) ? per : lim;
    half_min = (m < CNT_W'(2)) ? CNT_W'(1) : (m >> 1);
  endfunction

  localparam logic [CNT_W-1:0] SLOW_LIM = CNT_W'(SLOW_SHORT);
  localparam logic [CNT_W-1:0] CAL_LIM = CNT_W'(CAL_SHORT);

  logic [1:0] code;
  logic hf_mode;
  logic [ACC_W-1:0] cal_thr;
  logic [11:0] mult;
  assign code = {rate_sel_hi_i, rate_sel_lo_i};
  assign hf_mode = !cal_scale_sel_i && (code == 2'h3);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // slow threshold is K_FULL << (3-code); the cal threshold divides it by
  // the multiplier, which reduces to one constant per scale setting, plus CAL_THR_HF in high-frequency mode
  always_comb begin
    if (hf_mode) begin
      cal_thr = CAL_THR_HF;
      mult = MULT_HF;
    end else if (cal_scale_sel_i) begin
      cal_thr = CAL_THR_HI;
      mult = MULT_HI_BASE >> code;
    end else begin
      cal_thr = CAL_THR_LO;
      mult = MULT_LO_BASE >> code;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [5:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  logic [ACC_W-1:0] acc_r, acc_nxt;
  logic [11:0] slow_cnt_r, slow_cnt_nxt;
  logic cal_evt, slow_evt;
  logic [CNT_W-1:0] cal_per_r, cal_per_nxt, cal_w_r, cal_w_nxt;
  logic [CNT_W-1:0] slow_per_r, slow_per_nxt, slow_w_r, slow_w_nxt;
  logic side_r, side_nxt;
  logic cal_o_r, cal_o_nxt, sa_r, sa_nxt, sb_r, sb_nxt;

  always_comb begin
    logic [ACC_W-1:0] sum;
    sum = '0;
    div_nxt = div_r;
    tick_nxt = 1'b0;
    acc_nxt = acc_r;
    slow_cnt_nxt = slow_cnt_r;
    cal_evt = 1'b0;
    slow_evt = 1'b0;
    // oscillator enable; all rates follow it
    if (div_r == OSC_DIV_LAST) begin
      div_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      div_nxt = div_r + 6'h01;
    end
    // below the no-load floor nothing accumulates, so no output can creep
    if (tick_r && (power_i >= PWR_MIN)) begin
      sum = acc_r + ACC_W'(power_i);
      if (sum >= cal_thr) begin
        acc_nxt = sum - cal_thr;
        cal_evt = 1'b1;
      end else begin
        acc_nxt = sum;
      end
    end
    // slow pulses integrate mult calibration overflows: the long average
    if (cal_evt) begin
      if (slow_cnt_r + 12'h001 >= mult) begin
        slow_cnt_nxt = '0;
        slow_evt = 1'b1;
      end else begin
        slow_cnt_nxt = slow_cnt_r + 12'h001;
      end
    end
  end

  always_comb begin
    cal_per_nxt = (cal_per_r == '1) ? cal_per_r : cal_per_r + CNT_W'(1);
    slow_per_nxt = (slow_per_r == '1) ? slow_per_r : slow_per_r + CNT_W'(1);
    cal_w_nxt = (cal_w_r != '0) ? cal_w_r - CNT_W'(1) : cal_w_r;
    slow_w_nxt = (slow_w_r != '0) ? slow_w_r - CNT_W'(1) : slow_w_r;
    side_nxt = side_r;
    // width uses the period just finished; a pulse arriving early restarts
    if (cal_evt) begin
      cal_per_nxt = '0;
      cal_w_nxt = hf_mode ? HF_WIDTH_CYC : half_min(cal_per_r, CAL_LIM);
    end
    if (slow_evt) begin
      slow_per_nxt = '0;
      slow_w_nxt = half_min(slow_per_r, SLOW_LIM);
      side_nxt = !side_r;
    end
    cal_o_nxt = (cal_w_nxt != '0);
    sa_nxt = !((slow_w_nxt != '0) && !side_nxt);
    sb_nxt = !((slow_w_nxt != '0) && side_nxt);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= '0;
      tick_r <= 1'b0;
      acc_r <= '0;
      slow_cnt_r <= '0;
      cal_per_r <= '1;
      slow_per_r <= '1;
      cal_w_r <= '0;
      slow_w_r <= '0;
      side_r <= 1'b1;
      cal_o_r <= 1'b0;
      sa_r <= 1'b1;
      sb_r <= 1'b1;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      acc_r <= acc_nxt;
      slow_cnt_r <= slow_cnt_nxt;
      cal_per_r <= cal_per_nxt;
      slow_per_r <= slow_per_nxt;
      cal_w_r <= cal_w_nxt;
      slow_w_r <= slow_w_nxt;
      side_r <= side_nxt;
      cal_o_r <= cal_o_nxt;
      sa_r <= sa_nxt;
      sb_r <= sb_nxt;
    end
  end

  assign cal_pulse_out_o = cal_o_r;
  assign slow_pulse_a_n_o = sa_r;
  assign slow_pulse_b_n_o = sb_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cal_len_r, slow_len_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_len_r <= '0;
      slow_len_r <= '0;
    end else begin
      cal_len_r <= cal_o_r ? cal_len_r + CNT_W'(1) : '0;
      slow_len_r <= (!sa_r || !sb_r) ? slow_len_r + CNT_W'(1) : '0;
    end
  end

  slow_alternate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(!slow_pulse_a_n_o && !slow_pulse_b_n_o)) else $error("both slow outputs low");
  slow_side_swap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    slow_evt |=> (side_r != $past(side_r))) else $error("slow side did not swap");
  slow_width_max_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(slow_pulse_a_n_o) |-> slow_len_r <= SLOW_LIM / 2) else $error("slow pulse too wide");
  slow_b_width_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(slow_pulse_b_n_o) |-> slow_len_r <= SLOW_LIM / 2) else $error("slow b pulse too wide");
  no_load_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (power_i < PWR_MIN) |=> (acc_r == $past(acc_r))) else $error("accumulated below floor");
  osc_tick_only_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !tick_r |=> (acc_r == $past(acc_r))) else $error("accumulated off tick");
  cal_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cal_evt |=> cal_pulse_out_o ##1 cal_pulse_out_o) else $error("cal pulse not started");
  hf_width_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ($fell(cal_pulse_out_o) && hf_mode && $stable(code)) |-> cal_len_r == HF_WIDTH_CYC)
    else $error("hf cal width wrong");
  cal_width_max_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ($fell(cal_pulse_out_o) && !hf_mode) |-> cal_len_r <= CAL_LIM / 2)
    else $error("cal pulse too wide");
  slow_from_cal_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    slow_evt |-> cal_evt && (slow_cnt_r + 12'h001 >= mult)) else $error("slow ratio broken");
  // judged against the threshold of the same cycle, so a mode switch cannot trip it
  acc_below_thr_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (tick_r && (acc_r < cal_thr)) |-> (acc_nxt < cal_thr))
    else $error("accumulator overran threshold");
endmodule

// >>> verif/ptp_counter_model.sv
// pulse counter standing in for the metering host on the output pins
`timescale 1ns/100ps
module ptp_counter_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // observed pulse pins
  input wire logic cal_pulse_out_i,
  input wire logic slow_pulse_a_n_i,
  input wire logic slow_pulse_b_n_i,
  // counts and last measured timing
  output int cal_count_o,
  output int slow_count_o,
  output int period_cyc_o,
  output int width_cyc_o
);
  logic cal_d_r;
  logic a_d_r;
  logic b_d_r;
  int since_r;
  int high_r;

  // --------------------------------------------------------------
  // edge counting
  // --------------------------------------------------------------
  // pins are sampled on the same clk_i as the output stage, so callers compare counts without slack
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {cal_d_r, a_d_r, b_d_r} <= 3'h3;
      cal_count_o <= 0;
      slow_count_o <= 0;
      period_cyc_o <= 0;
      width_cyc_o <= 0;
      since_r <= 0;
      high_r <= 0;
    end else begin
      cal_d_r <= cal_pulse_out_i;
      a_d_r <= slow_pulse_a_n_i;
      b_d_r <= slow_pulse_b_n_i;
      since_r <= since_r + 1;
      if (cal_pulse_out_i) high_r <= high_r + 1;
      if (cal_pulse_out_i && !cal_d_r) begin
        cal_count_o <= cal_count_o + 1;
        period_cyc_o <= since_r + 1;
        since_r <= 0;
        high_r <= 1;
      end
      if (!cal_pulse_out_i && cal_d_r) width_cyc_o <= high_r;
      if ((!slow_pulse_a_n_i && a_d_r) || (!slow_pulse_b_n_i && b_d_r)) begin
        slow_count_o <= slow_count_o + 1;
      end
    end
  end
endmodule

// >>> verif/ptp_out_tb_top.sv
// self-checking testbench for the pulse-rate output stage
`timescale 1ns/100ps
module ptp_out_tb_top;
  import ptp_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [PWR_W-1:0] power_i = 16'h0000;
  logic rate_sel_lo_i = 1'b1;
  logic rate_sel_hi_i = 1'b1;
  logic cal_scale_sel_i = 1'b0;
  logic slow_pulse_a_n_o;
  logic slow_pulse_b_n_o;
  logic cal_pulse_out_o;
  int cal_count;
  int slow_count;
  int period_cyc;
  int width_cyc;
  int bad_count = 0;
  int checks_done = 0;

  initial forever #20 clk_i = ~clk_i;

  ptp_out #(.SLOW_SHORT(2000), .CAL_SHORT(600)) i_ptp_out (
    .clk_i(clk_i), .nrst_i(nrst_i), .power_i(power_i),
    .rate_sel_lo_i(rate_sel_lo_i), .rate_sel_hi_i(rate_sel_hi_i),
    .cal_scale_sel_i(cal_scale_sel_i), .slow_pulse_a_n_o(slow_pulse_a_n_o),
    .slow_pulse_b_n_o(slow_pulse_b_n_o), .cal_pulse_out_o(cal_pulse_out_o));
  ptp_counter_model i_ptp_counter_model (
    .clk_i(clk_i), .nrst_i(nrst_i), .cal_pulse_out_i(cal_pulse_out_o),
    .slow_pulse_a_n_i(slow_pulse_a_n_o), .slow_pulse_b_n_i(slow_pulse_b_n_o),
    .cal_count_o(cal_count), .slow_count_o(slow_count),
    .period_cyc_o(period_cyc), .width_cyc_o(width_cyc));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic check(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      bad_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // bounded wait for n further calibration pulses; the host window is cut far
  // below seconds here, and three pulses at full scale take about 26k cycles
  task automatic wait_cal(input int n);
    int start;
    int i;
    start = cal_count;
    for (i = 0; i < 30000 && cal_count < start + n; i++) @(negedge clk_i);
    check(cal_count >= start + n, "calibration pulses missing");
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic test_reset;
    check(slow_pulse_a_n_o === 1'b1 && slow_pulse_b_n_o === 1'b1, "slow not idle");
    check(cal_pulse_out_o === 1'b0, "cal not idle");
    $display("test_reset done");
  endtask

  // period must be a whole number of oscillator ticks around threshold/power
  task automatic test_hf(input logic [PWR_W-1:0] p);
    longint lo;
    lo = longint'(CAL_THR_HF) / longint'(p);
    power_i = p;
    wait_cal(3);
    check(period_cyc == lo * OSC_DIV || period_cyc == (lo + 1) * OSC_DIV, "cal period");
    check(width_cyc == int'(HF_WIDTH_CYC), "hf pulse width");
    check(slow_count == 0 && slow_pulse_a_n_o === 1'b1, "slow pulse too early");
    $display("test_hf done");
  endtask

  task automatic test_noload;
    int n;
    power_i = 16'h0001;
    n = cal_count;
    repeat (6000) @(negedge clk_i);
    check(cal_count == n && cal_pulse_out_o === 1'b0, "pulse below floor");
    $display("test_noload done");
  endtask

  // leaving high-frequency mode raises the threshold, so pulses stop
  task automatic test_mode;
    int n;
    cal_scale_sel_i = 1'b1;
    rate_sel_lo_i = 1'b0;
    power_i = 16'hFFFF;
    n = cal_count;
    repeat (5000) @(negedge clk_i);
    check(cal_count == n && slow_count == 0, "multiplier not applied");
    $display("test_mode done");
  endtask

  initial begin
    repeat (6) @(negedge clk_i);
    test_reset;
    nrst_i = 1'b1;
    test_hf(16'hFFFF);
    test_hf(16'h8000);
    test_hf(PWR_FS);
    test_noload;
    test_mode;
    stop_test;
  end

  // the scenarios need roughly 60k cycles
  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule
